// file: design/sync_serial_data_adapter.v
// Synchronous serial data adapter: register port, 3-deep transmit and
// receive FIFOs, transmitter with fill and parity, sync-hunting receiver.
// Assumes serial clocks and modem lines are asynchronous pins well slower
// than clk_sys_i; they are synchronised and the clock edges detected here.
//
// Contract
// - Two bus locations; select, direction and the control 1 address field pick the internal register.
// - Seven registers: status, rx data readable; others write-only.
// - Tx data enters a three-entry FIFO, settling to last empty slot.
// - Status flag shows whether tx FIFO can take another byte; outside external mode clear-to-send high forces it low.
// - Oldest buffered byte moves to tx shifter when it is ready.
// - On underflow load sync code or all-ones, as configured.
// - Transmitter adds even, odd or no parity bit.
// - Clear-to-send high inhibits transmitter, FIFO contents kept.
// - External mode aligns characters from carrier detect input.
// - Single-sync mode forwards nothing until one sync code matches.
// - Double-sync mode needs two consecutive sync codes.
// - Once synced, assemble characters and optionally check parity.
// - Parity error marker travels through rx FIFO with its character.
// - Status shows rx character available and its parity error.
// - Separate tx and rx clocks, running independently and together.
// - Reset latches device in reset, no spurious output transitions.
// - Reset presets receiver shift register to all ones.
// - Underflow status stays set until clear-underflow bit written.
// - Transmitter reset bit empties tx FIFO and clears room flag.
`timescale 1ns/1ps
`include "sync_serial_data_adapter_consts.vh"

////////////////////////////////////////////////////////////////////////
module sync_adapter_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 3,
  parameter CNT_W = 2
) (
  input  wire             clk_sys_i,
  input  wire             rst_b_i,
  input  wire             clr_i,
  input  wire             push_i,
  input  wire             pop_i,
  input  wire [WIDTH-1:0] din_i,
  output wire [WIDTH-1:0] head_o,
  output reg  [CNT_W-1:0] count_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];

  assign head_o = mem_q[0];

  // Each entry moves down on pop; new data lands in last empty slot
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      localparam [CNT_W-1:0] IDX  = i;
      localparam [CNT_W-1:0] IDX1 = i + 1;
      always @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mem_q[i] <= {WIDTH{1'b0}};
        else if (pop_i)
        begin
          if (push_i && count_o == IDX1)
            mem_q[i] <= din_i;
          else
            mem_q[i] <= (i == DEPTH - 1) ? {WIDTH{1'b0}} : mem_q[(i + 1) % DEPTH];
        end
        else if (push_i && count_o == IDX)
          mem_q[i] <= din_i;
      end
    end
  endgenerate

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      count_o <= {CNT_W{1'b0}};
    else if (clr_i)
      count_o <= {CNT_W{1'b0}};
    else if (push_i && !pop_i)
      count_o <= count_o + 1'b1;
    else if (pop_i && !push_i)
      count_o <= count_o - 1'b1;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module sync_serial_data_adapter #(
  parameter TX_DEPTH = 3,
  parameter RX_DEPTH = 3,
  parameter CNT_W    = 2
) (
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  input  wire       register_select_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_stb_i,
  input  wire       rd_stb_i,
  output reg  [7:0] rd_data_o,
  input  wire       tx_clk_i,
  input  wire       rx_clk_i,
  input  wire       rx_data_i,
  input  wire       carrier_detect_in_i,
  input  wire       cts_i,
  output reg        tx_data_o,
  output reg        sync_match_terminal_ready_o,
  output reg        transmit_underflow_out_o
);
  localparam ST_HUNT   = 2'h0;
  localparam ST_SECOND = 2'h1;
  localparam ST_SYNCED = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edges
  wire [4:0] pin_raw = {carrier_detect_in_i, cts_i, tx_clk_i, rx_data_i, rx_clk_i};
  reg  [4:0] pin_meta_q;
  reg  [4:0] pin_q;
  reg  [4:0] pin_prev_q;

  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1)
    begin : g_pin
      always @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          pin_meta_q[p] <= 1'b0;
          pin_q[p]      <= 1'b0;
          pin_prev_q[p] <= 1'b0;
        end
        else
        begin
          pin_meta_q[p] <= pin_raw[p];
          pin_q[p]      <= pin_meta_q[p];
          pin_prev_q[p] <= pin_q[p];
        end
      end
    end
  endgenerate

  wire rxc_rise = pin_q[0] & ~pin_prev_q[0];
  wire rxd      = pin_q[1];
  wire txc_rise = pin_q[2] & ~pin_prev_q[2];
  wire txc_fall = ~pin_q[2] & pin_prev_q[2];
  wire cts_s    = pin_q[3];
  wire dcd_s    = pin_q[4];

  ////////////////////////////////////////////////////////////////////
  // Register port
  reg  [7:0] ctl1_q;
  reg  [7:0] ctl2_q;
  reg  [7:0] ctl3_q;
  reg  [7:0] sync_code_q;

  wire [1:0] addr_ctl = ctl1_q[`C1_AC_HI:`C1_AC_LO];
  wire       wr_lo    = wr_stb_i & (register_select_i == `LOC_CTRL_STAT);
  wire       wr_hi    = wr_stb_i & (register_select_i == `LOC_DATA);
  wire       wr_ctl2  = wr_hi & (addr_ctl == `AC_CTL2);
  wire       wr_ctl3  = wr_hi & (addr_ctl == `AC_CTL3);
  wire       wr_sync  = wr_hi & (addr_ctl == `AC_SYNC);
  wire       wr_tx    = wr_hi & (addr_ctl == `AC_TXDATA);
  wire       clr_uf   = wr_ctl3 & wr_data_i[`C3_CLR_UF];

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctl1_q      <= `C1_RESET;
      ctl2_q      <= `C2_RESET;
      ctl3_q      <= `C3_RESET;
      sync_code_q <= `SYNC_RESET;
    end
    else
    begin
      if (wr_lo)
        ctl1_q <= wr_data_i;
      if (wr_ctl2)
        ctl2_q <= wr_data_i;
      if (wr_ctl3)
        ctl3_q <= wr_data_i;
      if (wr_sync)
        sync_code_q <= wr_data_i;
    end
  end

  wire       tx_rst   = ctl1_q[`C1_TX_RST];
  wire       rx_rst   = ctl1_q[`C1_RX_RST];
  wire       par_en   = ctl2_q[`C2_PAR_EN];
  wire       par_odd  = ctl2_q[`C2_PAR_ODD];
  wire       uf_sync  = ctl2_q[`C2_UF_SYNC];
  wire [1:0] mode     = ctl3_q[`C3_MODE_HI:`C3_MODE_LO];
  wire       ext_mode = (mode == `MODE_EXT_SYNC);

  ////////////////////////////////////////////////////////////////////
  // Transmit FIFO and shifter
  wire [7:0]       tx_head;
  wire [CNT_W-1:0] tx_cnt;
  wire             tx_inhibit = tx_rst | cts_s;
  reg              tx_pend_q;
  reg              tx_pend_uf_q;
  reg              tx_busy_q;
  reg  [3:0]       tx_bit_q;
  reg  [8:0]       tx_shift_q;
  reg              uf_flag_q;

  wire             tx_full  = (tx_cnt == TX_DEPTH);
  wire             tx_push  = wr_tx & ~tx_full & ~tx_rst;
  wire             tx_load  = txc_fall & tx_pend_q & ~tx_inhibit;
  wire             tx_pop   = tx_load & ~tx_pend_uf_q;
  wire [3:0]       tx_last  = par_en ? 4'h8 : 4'h7;
  wire [7:0]       fill     = uf_sync ? sync_code_q : `MARK_CHAR;
  wire [7:0]       tx_char  = tx_pend_uf_q ? fill : tx_head;
  wire             tx_par   = ^tx_char ^ par_odd;
  wire             tx_room  = ~tx_full & ~tx_rst & ~(cts_s & ~ext_mode);

  sync_adapter_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH),
    .CNT_W (CNT_W)
  ) u_tx_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (tx_rst),
    .push_i    (tx_push),
    .pop_i     (tx_pop),
    .din_i     (wr_data_i),
    .head_o    (tx_head),
    .count_o   (tx_cnt)
  );

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_pend_q                <= 1'b0;
      tx_pend_uf_q             <= 1'b0;
      tx_busy_q                <= 1'b0;
      tx_bit_q                 <= 4'h0;
      tx_shift_q               <= 9'h1ff;
      tx_data_o                <= 1'b1;
      transmit_underflow_out_o <= 1'b0;
    end
    else if (tx_inhibit)
    begin
      tx_pend_q                <= 1'b0;
      tx_busy_q                <= 1'b0;
      tx_bit_q                 <= 4'h0;
      tx_data_o                <= 1'b1;
      transmit_underflow_out_o <= 1'b0;
    end
    else if (txc_rise && !tx_pend_q && (!tx_busy_q || tx_bit_q == tx_last))
    begin
      // Decide next character during the high half of the last bit
      tx_pend_q                <= 1'b1;
      tx_pend_uf_q             <= (tx_cnt == {CNT_W{1'b0}});
      transmit_underflow_out_o <= (tx_cnt == {CNT_W{1'b0}}) & uf_sync;
    end
    else if (txc_fall)
    begin
      transmit_underflow_out_o <= 1'b0;
      if (tx_pend_q)
      begin
        tx_pend_q  <= 1'b0;
        tx_busy_q  <= 1'b1;
        tx_bit_q   <= 4'h0;
        tx_shift_q <= {tx_par, tx_char};
        tx_data_o  <= tx_char[0];
      end
      else if (tx_busy_q)
      begin
        tx_bit_q   <= tx_bit_q + 4'h1;
        tx_shift_q <= {1'b1, tx_shift_q[8:1]};
        tx_data_o  <= tx_shift_q[1];
      end
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      uf_flag_q <= 1'b0;
    else if (tx_load && tx_pend_uf_q)
      uf_flag_q <= 1'b1;
    else if (clr_uf)
      uf_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Receiver sync hunt and character assembly
  reg  [1:0] rx_state_q;
  reg  [7:0] rx_shift_q;
  reg  [3:0] rx_bit_q;
  reg        sm_q;
  reg        ovr_q;

  wire       clr_sync  = ctl1_q[`C1_CLR_SYNC];
  wire [7:0] rx_next   = {rxd, rx_shift_q[7:1]};
  wire [3:0] rx_last   = par_en ? 4'h8 : 4'h7;
  wire       rx_hold   = clr_sync | (ext_mode & ~dcd_s);
  wire       ext_align = ext_mode & dcd_s & (rx_state_q == ST_HUNT);
  wire       rx_step   = ~rx_rst & ~rx_hold & ~ext_align & rxc_rise;
  wire       rx_end    = rx_step & (rx_state_q == ST_SYNCED) & (rx_bit_q == rx_last);
  wire [7:0] rx_char   = par_en ? rx_shift_q : rx_next;
  wire       rx_perr   = par_en & (^{rx_shift_q, rxd} ^ par_odd);
  wire       strip     = ctl1_q[`C1_STRIP_SYNC] & (rx_char == sync_code_q);
  wire [8:0] rx_head;
  wire [CNT_W-1:0] rx_cnt;
  wire       rx_full   = (rx_cnt == RX_DEPTH);
  wire       rx_push   = rx_end & ~strip & ~rx_full;
  wire       rd_data   = rd_stb_i & (register_select_i == `LOC_DATA);
  wire       rx_ready  = (rx_cnt != {CNT_W{1'b0}});
  wire       rx_pop    = rd_data & rx_ready;

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_state_q <= ST_HUNT;
      rx_shift_q <= `RX_SHIFT_RESET;
      rx_bit_q   <= 4'h0;
      sm_q       <= 1'b0;
    end
    else if (rx_rst)
    begin
      rx_state_q <= ST_HUNT;
      rx_shift_q <= `RX_SHIFT_RESET;
      rx_bit_q   <= 4'h0;
      sm_q       <= 1'b0;
    end
    else if (rx_hold)
    begin
      rx_state_q <= ST_HUNT;
      rx_bit_q   <= 4'h0;
      sm_q       <= 1'b0;
    end
    else if (ext_align)
    begin
      rx_state_q <= ST_SYNCED;
      rx_bit_q   <= 4'h0;
    end
    else if (rx_step)
    begin
      sm_q <= 1'b0;
      case (rx_state_q)
        ST_HUNT:
        begin
          rx_shift_q <= rx_next;
          if (rx_next == sync_code_q)
          begin
            sm_q       <= 1'b1;
            rx_bit_q   <= 4'h0;
            rx_state_q <= (mode == `MODE_TWO_SYNC) ? ST_SECOND : ST_SYNCED;
          end
        end
        ST_SECOND:
        begin
          rx_shift_q <= rx_next;
          rx_bit_q   <= rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h7)
          begin
            rx_bit_q   <= 4'h0;
            sm_q       <= (rx_next == sync_code_q);
            rx_state_q <= (rx_next == sync_code_q) ? ST_SYNCED : ST_HUNT;
          end
        end
        ST_SYNCED:
        begin
          if (rx_bit_q != 4'h8)
            rx_shift_q <= rx_next;
          rx_bit_q <= (rx_bit_q == rx_last) ? 4'h0 : rx_bit_q + 4'h1;
        end
        default:
          rx_state_q <= ST_HUNT;
      endcase
    end
  end

  sync_adapter_fifo #(
    .WIDTH (9),
    .DEPTH (RX_DEPTH),
    .CNT_W (CNT_W)
  ) u_rx_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .clr_i     (rx_rst),
    .push_i    (rx_push),
    .pop_i     (rx_pop),
    .din_i     ({rx_perr, rx_char}),
    .head_o    (rx_head),
    .count_o   (rx_cnt)
  );

  // Overrun: character lost to a full FIFO; set beats the clearing read
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ovr_q <= 1'b0;
    else if (rx_end && !strip && rx_full)
      ovr_q <= 1'b1;
    else if (rd_data || rx_rst)
      ovr_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Status, read data and modem output
  wire [7:0] status;
  assign status[`ST_RX_READY]  = rx_ready;
  assign status[`ST_TX_ROOM]   = tx_room;
  assign status[`ST_CARRIER]   = dcd_s;
  assign status[`ST_CTS]       = cts_s;
  assign status[`ST_UNDERFLOW] = uf_flag_q;
  assign status[`ST_OVERRUN]   = ovr_q;
  assign status[`ST_PAR_ERR]   = rx_ready & rx_head[8];
  assign status[`ST_IN_SYNC]   = (rx_state_q == ST_SYNCED);

  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_data_o                   <= 8'h00;
      sync_match_terminal_ready_o <= 1'b0;
    end
    else
    begin
      if (!rd_stb_i)
        rd_data_o <= 8'h00;
      else if (register_select_i == `LOC_CTRL_STAT)
        rd_data_o <= status;
      else
        rd_data_o <= rx_head[7:0];
      sync_match_terminal_ready_o <= ctl2_q[`C2_SM_SEL] ? sm_q : ctl2_q[`C2_TERM_READY];
    end
  end
endmodule

// file: design/sync_serial_data_adapter_consts.vh
// Constants for the synchronous serial data adapter: bus map, control
// and status bit positions, reset values and mode codes.
// Assumes inclusion by bare name from the adapter design file.
`ifndef SYNC_SERIAL_DATA_ADAPTER_CONSTS_VH
`define SYNC_SERIAL_DATA_ADAPTER_CONSTS_VH

// Bus locations (register_select)
`define LOC_CTRL_STAT    1'b0
`define LOC_DATA         1'b1

// Address control field of control 1 steering writes to the data location
`define AC_CTL2          2'h0
`define AC_CTL3          2'h1
`define AC_SYNC          2'h2
`define AC_TXDATA        2'h3

// Control 1
`define C1_RX_RST        0
`define C1_TX_RST        1
`define C1_STRIP_SYNC    2
`define C1_CLR_SYNC      3
`define C1_AC_LO         6
`define C1_AC_HI         7
`define C1_RESET         8'h03

// Control 2
`define C2_SM_SEL        0
`define C2_UF_SYNC       1
`define C2_PAR_EN        2
`define C2_PAR_ODD       3
`define C2_TERM_READY    4
`define C2_RESET         8'h00

// Control 3
`define C3_MODE_LO       0
`define C3_MODE_HI       1
`define C3_CLR_UF        2
`define C3_RESET         8'h00

// Sync modes
`define MODE_ONE_SYNC    2'h0
`define MODE_TWO_SYNC    2'h1
`define MODE_EXT_SYNC    2'h2

`define SYNC_RESET       8'h00
`define MARK_CHAR        8'hff
`define RX_SHIFT_RESET   8'hff

// Status bits
`define ST_RX_READY      0
`define ST_TX_ROOM       1
`define ST_CARRIER       2
`define ST_CTS           3
`define ST_UNDERFLOW     4
`define ST_OVERRUN       5
`define ST_PAR_ERR       6
`define ST_IN_SYNC       7

`endif

// file: tb/adapter_props.sv
// Port checker for the serial adapter: bus answers, reset levels,
// transmitter hold-off and underflow pulse.
// Assumes control writes follow the bus map of the constants header.
`timescale 1ns/1ps
`include "sync_serial_data_adapter_consts.vh"
module adapter_props (
  input wire       clk_sys_i,
  input wire       rst_b_i,
  input wire       register_select_i,
  input wire [7:0] wr_data_i,
  input wire       wr_stb_i,
  input wire       rd_stb_i,
  input wire [7:0] rd_data_o,
  input wire       cts_i,
  input wire       tx_data_o,
  input wire       sync_match_terminal_ready_o,
  input wire       transmit_underflow_out_o
);
  reg  [7:0] c1_q;
  reg  [7:0] c2_q;
  reg  [7:0] c3_q;
  wire       st_rd;
  assign st_rd = rd_stb_i && !register_select_i;
  // Shadow copies of the write-only controls
  always @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      c1_q <= `C1_RESET;
      c2_q <= `C2_RESET;
      c3_q <= `C3_RESET;
    end
    else if (wr_stb_i && !register_select_i)
      c1_q <= wr_data_i;
    else if (wr_stb_i && c1_q[7:6] == `AC_CTL2)
      c2_q <= wr_data_i;
    else if (wr_stb_i && c1_q[7:6] == `AC_CTL3)
      c3_q <= wr_data_i;
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  property p_rd_quiet;
    !rd_stb_i |=> rd_data_o == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside read slot");
  property p_rst_out;
    $rose(rst_b_i) |-> tx_data_o && !transmit_underflow_out_o
      && !sync_match_terminal_ready_o;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not idle after reset");
  property p_txrst_line;
    (c1_q[`C1_TX_RST])[*3] |-> tx_data_o;
  endproperty
  a_txrst_line: assert property (p_txrst_line)
    else $error("tx line moves in tx reset");
  property p_room_txrst;
    st_rd && c1_q[`C1_TX_RST] |=> !rd_data_o[`ST_TX_ROOM];
  endproperty
  a_room_txrst: assert property (p_room_txrst)
    else $error("room flag set in tx reset");
  property p_cts_line;
    cts_i[*6] |-> tx_data_o;
  endproperty
  a_cts_line: assert property (p_cts_line)
    else $error("tx line moves with cts high");
  property p_room_cts;
    cts_i[*6] ##0 (st_rd && c3_q[1:0] != `MODE_EXT_SYNC)
      |=> !rd_data_o[`ST_TX_ROOM];
  endproperty
  a_room_cts: assert property (p_room_cts)
    else $error("room flag set with cts high");
  property p_tuf_mode;
    transmit_underflow_out_o |-> c2_q[`C2_UF_SYNC];
  endproperty
  a_tuf_mode: assert property (p_tuf_mode)
    else $error("underflow pulse in mark fill");
  property p_tuf_width;
    $rose(transmit_underflow_out_o) |-> transmit_underflow_out_o[*3]
      ##[1:3] !transmit_underflow_out_o;
  endproperty
  a_tuf_width: assert property (p_tuf_width)
    else $error("underflow pulse width wrong");
  c_tuf: cover property ($rose(transmit_underflow_out_o));
  c_cts_rd: cover property (st_rd && cts_i);
  c_data_rd: cover property (rd_stb_i && register_select_i);
endmodule

// file: tb/link_partner.sv
// Far side of the serial link: makes both link clocks, feeds the
// receive line and captures the transmit line. Clocks idle low.
// Assumes the adapter oversamples both link clocks with a faster clock.
`timescale 1ns/1ps
module link_partner #(
  parameter HALF = 100
) (
  input  wire tx_data_i,
  output reg  tx_clk_o,
  output reg  rx_clk_o,
  output reg  rx_data_o
);
  initial
  begin
    tx_clk_o = 1'b0;
    rx_clk_o = 1'b0;
    rx_data_o = 1'b1;
  end
  // n+1 periods; bit k taken late in high phase k+1
  task tx_run(input integer n, output reg [39:0] bits);
    integer k;
    begin
      bits = 40'h0;
      #7;
      for (k = 0; k <= n; k = k + 1)
      begin
        tx_clk_o = 1'b1;
        #HALF;
        if (k > 0)
          bits[k-1] = tx_data_i;
        tx_clk_o = 1'b0;
        #HALF;
      end
    end
  endtask
  // LSB first; line inverted once the burst ends
  task rx_send(input integer n, input [39:0] bits);
    integer k;
    begin
      #11;
      for (k = 0; k < n; k = k + 1)
      begin
        rx_data_o = bits[k];
        #HALF;
        rx_clk_o = 1'b1;
        #HALF;
        rx_clk_o = 1'b0;
      end
      rx_data_o = ~rx_data_o;
    end
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the serial adapter, one task per scenario.
// Assumes the link partner model and the bound port checker.
`timescale 1ns/1ps
`include "sync_serial_data_adapter_consts.vh"
module testbench;
  localparam [7:0] SYNC = 8'h16;
  reg         clk_sys_i;
  reg         rst_b_i;
  reg         sel;
  reg  [7:0]  wdat;
  reg         wr;
  reg         rd;
  reg         cts;
  reg         carrier;
  wire [7:0]  rdat;
  wire        tx_clk;
  wire        rx_clk;
  wire        rx_dat;
  wire        tx_dat;
  wire        sm_out;
  integer     fail_count;
  integer     n_compared;
  sync_serial_data_adapter DUT (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .register_select_i(sel),
    .wr_data_i(wdat), .wr_stb_i(wr), .rd_stb_i(rd), .rd_data_o(rdat),
    .tx_clk_i(tx_clk), .rx_clk_i(rx_clk), .rx_data_i(rx_dat),
    .carrier_detect_in_i(carrier), .cts_i(cts), .tx_data_o(tx_dat),
    .sync_match_terminal_ready_o(sm_out), .transmit_underflow_out_o());
  link_partner u_link (
    .tx_data_i(tx_dat), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk),
    .rx_data_o(rx_dat));
  always #12.5 clk_sys_i = ~clk_sys_i;
  task chk(input [8:0] got, input [8:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        fail_count = fail_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input s, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      sel <= s;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input s, output [7:0] d);
    begin
      @(posedge clk_sys_i);
      sel <= s;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      @(negedge clk_sys_i);
      d = rdat;
    end
  endtask
  task st_chk(input [7:0] mask, input [7:0] exp);
    reg [7:0] v;
    begin
      rd_reg(1'b0, v);
      chk({1'b0, v & mask}, {1'b0, exp});
    end
  endtask
  task rx_byte_chk(input [7:0] exp);
    reg [7:0] v;
    begin
      rd_reg(1'b1, v);
      chk({1'b0, v}, {1'b0, exp});
    end
  endtask
  // Sync code, control 3 and 2 with both resets held, then control 1 written from c1
  task cfg(input [1:0] mode, input [7:0] c2, input [7:0] c1);
    begin
      wr_reg(1'b0, 8'h83);
      wr_reg(1'b1, SYNC);
      wr_reg(1'b0, 8'h43);
      wr_reg(1'b1, {6'h0, mode});
      wr_reg(1'b0, 8'h03);
      wr_reg(1'b1, c2);
      wr_reg(1'b0, c1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      st_chk(8'hff, 8'h00);
      rx_byte_chk(8'h00);
    end
  endtask
  task t_tx(input [7:0] c2, input [7:0] b0);
    reg [39:0] got;
    reg [7:0]  ch;
    integer    w;
    integer    i;
    begin
      w = c2[`C2_PAR_EN] ? 9 : 8;
      @(posedge clk_sys_i);
      cts <= 1'b1;
      cfg(`MODE_ONE_SYNC, c2, 8'hc3);
      wr_reg(1'b1, 8'h99);
      wr_reg(1'b0, 8'hc1);
      st_chk(8'h0a, 8'h08);
      for (i = 0; i < 3; i = i + 1)
        wr_reg(1'b1, b0 + i[7:0]);
      u_link.tx_run(9, got);
      chk(got[8:0], 9'h1ff);
      @(posedge clk_sys_i);
      cts <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      st_chk(8'h0a, 8'h00);
      wr_reg(1'b1, 8'h5e);
      u_link.tx_run(4 * w, got);
      for (i = 0; i < 4; i = i + 1)
      begin
        ch = (i == 3) ? (c2[`C2_UF_SYNC] ? SYNC : `MARK_CHAR) : b0 + i[7:0];
        chk({1'b0, got[i*w +: 8]}, {1'b0, ch});
        if (w == 9 && i < 3)
          chk({8'h0, got[i*9+8]}, {8'h0, ^ch ^ c2[`C2_PAR_ODD]});
      end
      st_chk(8'h10, 8'h10);
      st_chk(8'h10, 8'h10);
      wr_reg(1'b0, 8'h41);
      wr_reg(1'b1, 8'h04);
      st_chk(8'h12, 8'h02);
    end
  endtask
  // Tx byte queued then flushed by tx reset; tx fill runs beside rx hunt
  task t_rx_one;
    reg [39:0] got;
    begin
      cfg(`MODE_ONE_SYNC, 8'h03, 8'hc0);
      wr_reg(1'b1, 8'h5a);
      wr_reg(1'b0, 8'hc2);
      wr_reg(1'b0, 8'hc0);
      u_link.rx_send(8, 40'h00);
      st_chk(8'h81, 8'h00);
      chk({8'h0, sm_out}, 9'h000);
      fork
        u_link.tx_run(8, got);
        u_link.rx_send(8, {32'h0, SYNC});
      join
      chk({1'b0, got[7:0]}, {1'b0, SYNC});
      st_chk(8'h81, 8'h80);
      chk({8'h0, sm_out}, 9'h001);
      u_link.rx_send(8, 40'ha5);
      st_chk(8'h81, 8'h81);
      chk({8'h0, sm_out}, 9'h000);
      rx_byte_chk(8'ha5);
      wr_reg(1'b0, 8'h0a);
      st_chk(8'h80, 8'h00);
    end
  endtask
  task t_rx_two;
    begin
      cfg(`MODE_TWO_SYNC, 8'h10, 8'h06);
      u_link.rx_send(8, {32'h0, SYNC});
      chk({8'h0, sm_out}, 9'h001);
      u_link.rx_send(8, 40'ha5);
      st_chk(8'h81, 8'h00);
      u_link.rx_send(8, {32'h0, SYNC});
      u_link.rx_send(8, {32'h0, SYNC});
      // Strip on: this sync after lock must not reach the FIFO
      u_link.rx_send(8, {32'h0, SYNC});
      u_link.rx_send(8, 40'h3c);
      st_chk(8'h81, 8'h81);
      rx_byte_chk(8'h3c);
      st_chk(8'h01, 8'h00);
    end
  endtask
  task t_rx_ext;
    reg [7:0] c;
    integer   i;
    begin
      cfg(`MODE_EXT_SYNC, 8'h04, 8'h02);
      @(posedge clk_sys_i);
      carrier <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      for (i = 0; i < 4; i = i + 1)
      begin
        c = 8'h50 + i[7:0];
        u_link.rx_send(9, {31'h0, ^c ^ (i == 1), c});
      end
      st_chk(8'h65, 8'h25);
      for (i = 0; i < 3; i = i + 1)
      begin
        st_chk(8'h41, (i == 1) ? 8'h41 : 8'h01);
        rx_byte_chk(8'h50 + i[7:0]);
      end
      st_chk(8'h01, 8'h00);
      @(posedge clk_sys_i);
      carrier <= 1'b0;
    end
  endtask
  task final_report;
    begin
      $display("compared=%0d mismatches=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    clk_sys_i = 1'b0;
    rst_b_i = 1'b0;
    sel = 1'b0;
    wdat = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cts = 1'b0;
    carrier = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_tx(8'h02, 8'h31);
    t_tx(8'h04, 8'hc4);
    t_tx(8'h0c, 8'h07);
    t_rx_one;
    t_rx_two;
    t_rx_ext;
    final_report;
  end
  // Whole run needs well under 100 us
  initial
  begin
    #500000;
    fail_count = fail_count + 1;
    final_report;
  end
endmodule
bind sync_serial_data_adapter adapter_props u_props (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
  .register_select_i(register_select_i), .wr_data_i(wr_data_i),
  .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .rd_data_o(rd_data_o),
  .cts_i(cts_i), .tx_data_o(tx_data_o),
  .sync_match_terminal_ready_o(sync_match_terminal_ready_o),
  .transmit_underflow_out_o(transmit_underflow_out_o));
